// [hdl/irq_return_ctrl.sv]
/*
 Execution control for return-from-interrupt and legacy option load.
 Assumes an instruction word valid on instrWord for a whole instruction cycle,
 an external return stack that pops on stackPop and shows its top on
 stack_top_entry, and a core that runs four clocks per instruction cycle.
 The four phases run from reset with no gaps, so a slow fetch must stretch
 the clock itself rather than pause the phases.
 Interrupt entry, the stack storage and the status register live outside.
 Only the enable bit of the interrupt control register is written here.
 The design is fully synchronous to clk, and sys_rst is sampled on it.
*/
`timescale 1ns/1ps
`include "irq_return_defines.svh"

// Contract
// - Decoding opcode 00 0000 0000 1001 pops one entry from the return stack.
// - The popped top of stack is loaded into the program counter.
// - Return from interrupt sets bit 7 of the interrupt control register to one.
// - It takes two instruction cycles, enable set in Q3, pop in Q4, second cycle idle.
module irq_return_ctrl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [13:0] instrWord,
    input wire logic [7:0] workingReg,
    input wire logic [12:0] stack_top_entry,
    output logic stackPop,
    output logic [12:0] programCounter,
    output logic [7:0] interrupt_control_reg,
    output logic global_irq_enable,
    output logic [7:0] optionReg,
    output logic fetchSuppress,
    output logic [3:0] phase,
    output logic statusWrite
);
    irq_return_pkg::phase_t phaseState;
    irq_return_pkg::phase_t next_phaseState;
    irq_return_pkg::exec_t execState;
    irq_return_pkg::exec_t next_execState;
    logic [12:0] next_programCounter;
    logic [7:0] next_interruptControl;
    logic [7:0] next_optionReg;

    // Exact match on the whole word; a looser decode would alias the
    // return op with the subroutine return that differs in bit 0
    function automatic logic opcodeMatch(
        input logic [13:0] word,
        input logic [13:0] code
    );
        return (word == code);
    endfunction

    // Program counter wraps within its 13-bit space
    function automatic logic [12:0] pcIncrement(
        input logic [12:0] pc
    );
        return pc + 13'h0001;
    endfunction

    // Shared phase compare for the atQ3 and atQ4 strobes
    function automatic logic phaseIs(
        input irq_return_pkg::phase_t current,
        input irq_return_pkg::phase_t wanted
    );
        return (current == wanted);
    endfunction

    wire logic idleCycle;
    assign idleCycle = (execState == irq_return_pkg::EX_IDLE);

    wire logic inNormal;
    wire logic isReturnOp;
    wire logic isOptionOp;
    wire logic return_from_interrupt_op;
    assign inNormal = (execState == irq_return_pkg::EX_NORMAL);
    assign isReturnOp = opcodeMatch(instrWord, `OPCODE_RETURN_FROM_IRQ);
    assign isOptionOp = opcodeMatch(instrWord, `OPCODE_OPTION_LOAD);
    assign return_from_interrupt_op = inNormal && isReturnOp;

    always_comb begin
        unique case (phaseState)
            irq_return_pkg::PH_Q1: begin
                next_phaseState = irq_return_pkg::PH_Q2;
            end
            irq_return_pkg::PH_Q2: begin
                next_phaseState = irq_return_pkg::PH_Q3;
            end
            irq_return_pkg::PH_Q3: begin
                next_phaseState = irq_return_pkg::PH_Q4;
            end
            irq_return_pkg::PH_Q4: begin
                next_phaseState = irq_return_pkg::PH_Q1;
            end
            // A corrupted one-hot code falls back to Q1
            default: begin
                next_phaseState = irq_return_pkg::PH_Q1;
            end
        endcase
    end

    wire logic atQ3;
    wire logic atQ4;
    assign atQ3 = phaseIs(phaseState, irq_return_pkg::PH_Q3);
    assign atQ4 = phaseIs(phaseState, irq_return_pkg::PH_Q4);

    // second cycle forced idle
    // The idle cycle ignores instrWord, so the word fetched from the
    // popped address only starts once the idle cycle has run out
    always_comb begin
        next_execState = execState;
        unique case (execState)
            irq_return_pkg::EX_NORMAL: begin
                if (atQ4 && isReturnOp) begin
                    next_execState = irq_return_pkg::EX_IDLE;
                end
            end
            irq_return_pkg::EX_IDLE: begin
                if (atQ4) begin
                    next_execState = irq_return_pkg::EX_NORMAL;
                end
            end
            default: begin
                next_execState = irq_return_pkg::EX_NORMAL;
            end
        endcase
    end

    assign stackPop = return_from_interrupt_op && atQ4;
    // Fetch holds off while the second cycle runs empty
    assign fetchSuppress = idleCycle;
    // Phase strobes for the rest of the core
    assign phase = phaseState;
    assign statusWrite = 1'b0;
    assign global_irq_enable = interrupt_control_reg[`GLOBAL_IRQ_ENABLE_BIT];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phaseState <= irq_return_pkg::PH_Q1;
        end else begin
            phaseState <= next_phaseState;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            execState <= irq_return_pkg::EX_NORMAL;
        end else begin
            execState <= next_execState;
        end
    end

    wire logic pcAdvance;
    wire logic gieSetNow;
    wire logic optionLoadNow;
    assign pcAdvance = atQ4 && inNormal;
    assign gieSetNow = return_from_interrupt_op && atQ3;
    // kept for old code only; newer code writes the register directly
    assign optionLoadNow = inNormal && isOptionOp && atQ4;

    // top of stack to PC
    // Pop wins over the increment so the return address is never skipped
    always_comb begin
        next_programCounter = programCounter;
        if (stackPop) begin
            next_programCounter = stack_top_entry;
        end else if (pcAdvance) begin
            next_programCounter = pcIncrement(programCounter);
        end
    end

    // only bit 7 written
    // The other bits belong to interrupt sources outside this block
    always_comb begin
        next_interruptControl = interrupt_control_reg;
        if (gieSetNow) begin
            next_interruptControl[`GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
        end
    end

    always_comb begin
        next_optionReg = optionReg;
        if (optionLoadNow) begin
            next_optionReg = workingReg;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            programCounter <= `PC_RESET;
        end else begin
            programCounter <= next_programCounter;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            interrupt_control_reg <= `INTERRUPT_CONTROL_RESET;
        end else begin
            interrupt_control_reg <= next_interruptControl;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            optionReg <= `OPTION_RESET;
        end else begin
            optionReg <= next_optionReg;
        end
    end
endmodule // irq_return_ctrl

// [hdl/irq_return_defines.svh]
/*
 Timing counts and field positions for the interrupt-return and option-load
 control. Assumes inclusion by bare name from hdl/.
*/
`ifndef IRQ_RETURN_DEFINES_SVH
`define IRQ_RETURN_DEFINES_SVH
`define OPCODE_RETURN_FROM_IRQ 14'h0009
`define OPCODE_OPTION_LOAD 14'h0062
`define GLOBAL_IRQ_ENABLE_BIT 7
`define INTERRUPT_CONTROL_RESET 8'h00
`define OPTION_RESET 8'hff
`define PC_RESET 13'h0000
`define PHASE_COUNT 4
`endif

// [hdl/irq_return_pkg.sv]
/*
 Types for the interrupt-return and option-load control.
 Assumes nothing of its surroundings.
*/
package irq_return_pkg;
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;
    typedef enum logic [1:0] {
        EX_NORMAL = 2'b01,
        EX_IDLE = 2'b10
    } exec_t;
endpackage

// [verif/irq_return_chk.sv]
/* Port checker for irq_return_ctrl. Assumes the bind below. */
`timescale 1ns/1ps
module irq_return_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [13:0] instrWord,
    input wire logic stackPop,
    input wire logic [12:0] programCounter,
    input wire logic [12:0] stack_top_entry,
    input wire logic global_irq_enable,
    input wire logic fetchSuppress,
    input wire logic statusWrite,
    input wire logic [3:0] phase
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence retQ3;
        phase == 4'h4 && instrWord == 14'h0009 && !fetchSuppress;
    endsequence
    sequence idleRun;
        fetchSuppress [*4] ##1 !fetchSuppress;
    endsequence
    a_pop_q4: assert property (retQ3 |=> stackPop) else $error("pop");
    a_pc_load: assert property (stackPop |=> programCounter == $past(stack_top_entry))
        else $error("pc");
    a_gie_set: assert property (retQ3 |=> global_irq_enable) else $error("gie");
    a_idle_cycle: assert property (stackPop |=> idleRun) else $error("idle");
    a_no_flags: assert property (!statusWrite) else $error("flags");
endmodule // irq_return_chk
bind irq_return_ctrl irq_return_chk chk_u (.*);

// [verif/prog_mem.sv]
/* Program memory model. Assumes the bench loads rom. */
`timescale 1ns/1ps
module prog_mem (
    input wire logic clk,
    input wire logic [12:0] programCounter,
    output logic [13:0] instrWord
);
    logic [13:0] rom [8192];
    initial instrWord = 14'h0000;
    always @(posedge clk) #1 instrWord = rom[programCounter];
endmodule // prog_mem

// [verif/testbench.sv]
/* Random program against a cycle model. Assumes prog_mem. */
`timescale 1ns/1ps
module testbench;
    logic clk = 0, sys_rst = 1, stackPop, global_irq_enable, fetchSuppress, statusWrite;
    logic [7:0] workingReg = 0, interrupt_control_reg, optionReg;
    logic [12:0] stack_top_entry = 0, programCounter;
    logic [13:0] instrWord, w;
    logic [3:0] phase;
    logic [13:0] ops [4] = '{14'h0009, 14'h0062, 14'h0008, 14'h0063};
    int seed = 87332, mismatches = 0, total_checks = 0, pcM = 0, optM = 255, gieM = 0, idle = 0;
    int expQ[$];
    irq_return_ctrl dut_u (.*);
    prog_mem pm_u (.*);
    initial forever #20 clk = ~clk;
    task chk(input logic [12:0] got, input logic [12:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 8192; i++) pm_u.rom[i] = ops[$random(seed) & 3];
        repeat (16) @(posedge clk);
        #1 sys_rst = 0;
        repeat (300) begin
            w = pm_u.rom[pcM];
            workingReg = 8'($random(seed));
            stack_top_entry = 13'($random(seed));
            chk(phase, 4'h1);
            if (idle) idle = 0;
            else if (w == 14'h0009) begin
                gieM = 1;
                pcM = stack_top_entry;
                idle = 1;
            end else begin
                if (w == 14'h0062) optM = workingReg;
                pcM = (pcM + 1) % 8192;
            end
            expQ.push_back(pcM);
            repeat (4) @(posedge clk);
            #1 chk(programCounter, 13'(expQ.pop_front()));
            chk(13'(interrupt_control_reg), 13'({gieM[0], 7'h00}));
            chk(optionReg, optM[7:0]);
            chk(global_irq_enable, gieM[0]);
            chk(fetchSuppress, idle[0]);
        end
        $display("random program test done");
        results();
    end
endmodule // testbench
